// ### dv/sfp_host_model.sv
`default_nettype none

module sfp_host_model (
    input  wire logic spi_dout,    // Device data out
    input  wire logic spi_dout_oe, // Device drives data out
    output var logic  spi_sel_n,   // Chip select, active low
    output var logic  spi_clk,     // Serial clock, low outside frames
    output var logic  spi_din,     // Serial data to device
    output var logic  wp_n         // Write protect, active low
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] rx;

    initial
    begin
        spi_sel_n = 1'b1;
        spi_clk = 1'b0;
        spi_din = 1'b0;
        wp_n = 1'b1;
    end

    // Never sends a power-down opcode; identification is refused only while a cycle runs
    task automatic frame(input logic [31:0] tx, input int n);
        rx = 32'h0;
        spi_sel_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            spi_din = tx[31 - i];
            #62.5 spi_clk = 1'b1;
            rx = {rx[30:0], spi_dout_oe ? spi_dout : 1'bz};
            #62.5 spi_clk = 1'b0;
        end
        #62.5 spi_sel_n = 1'b1;
        spi_din = ~spi_din;
        #100;
    endtask : frame
endmodule : sfp_host_model

`default_nettype wire

// ### dv/sfp_status_protect_chk.sv
`default_nettype none

module sfp_chk (
    input wire logic        mclk,        // System clock
    input wire logic        resetn,      // Synchronous reset, active low
    input wire logic        spi_sel_n,   // Chip select pin
    input wire logic        wp_n,        // Write protect pin
    input wire logic        array_busy,  // Sequencer busy
    input wire logic        spi_dout_oe, // Data out drive enable
    input wire logic        array_go,    // Sequencer start pulse
    input wire logic [1:0]  array_op,    // Operation kind
    input wire logic [23:0] array_addr,  // Operation address
    input wire logic [7:0]  status_byte, // Status register copy
    input wire logic        hw_protect   // Hardware protected mode
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // Four cycles leave room for the pin synchroniser
    property p_hpm_on;
        (status_byte[7] && !wp_n) [*4] |-> hw_protect;
    endproperty
    a_hpm_on: assert property (p_hpm_on) else $error("protect mode not entered");
    property p_hpm_off;
        (wp_n || !status_byte[7]) [*4] |-> !hw_protect;
    endproperty
    a_hpm_off: assert property (p_hpm_off) else $error("protect mode not left");
    property p_freeze;
        hw_protect [*2] |-> $stable(status_byte[7:2]);
    endproperty
    a_freeze: assert property (p_freeze) else $error("locked bits changed");
    property p_rsvd;
        status_byte[6:5] == 2'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    property p_oe_off;
        spi_sel_n [*6] |-> !spi_dout_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("output driven while idle");
    property p_bulk;
        array_go && array_op == 2'h3 |-> status_byte[4:2] == 3'h0;
    endproperty
    a_bulk: assert property (p_bulk) else $error("bulk erase while protected");
    property p_lock;
        array_go && array_op == 2'h2 && status_byte[4:2] == 3'h1 |-> array_addr[18:16] != 3'h7;
    endproperty
    a_lock: assert property (p_lock) else $error("locked sector erased");
    property p_go_latch;
        array_go |-> status_byte[1] && !status_byte[0];
    endproperty
    a_go_latch: assert property (p_go_latch) else $error("start without latch");
    property p_busy;
        array_busy [*3] |-> status_byte[0];
    endproperty
    a_busy: assert property (p_busy) else $error("busy flag low");
    property p_wel_clr;
        $fell(status_byte[0]) |-> ##[0:2] !status_byte[1];
    endproperty
    a_wel_clr: assert property (p_wel_clr) else $error("latch kept after cycle");
endmodule : sfp_chk

bind sfp_status_protect sfp_chk sfp_chk_i (.mclk, .resetn, .spi_sel_n, .wp_n, .array_busy,
    .spi_dout_oe, .array_go, .array_op, .array_addr, .status_byte, .hw_protect);

`default_nettype wire

// ### dv/tb.sv
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int         TW  = 10000;
    localparam logic [7:0] MFR = 8'hc3; // Arbitrary value
    localparam logic [7:0] TYP = 8'h71; // Arbitrary value
    localparam logic [7:0] CAP = 8'h2e; // Arbitrary value
    logic        mclk       = 1'b0;
    logic        resetn     = 1'b0;
    logic        array_busy = 1'b0;
    logic        array_done = 1'b0;
    logic [15:0] busy_cnt   = 16'h0;
    logic [1:0]  go_op      = 2'h0;
    logic [23:0] go_addr    = 24'h0;
    logic [31:0] rx;
    logic [7:0]  st;
    int          go_n, err_count, tests_run;
    wire logic        spi_sel_n, spi_clk, spi_din, wp_n, spi_dout, spi_dout_oe;
    wire logic        array_go, hw_protect;
    wire logic [1:0]  array_op;
    wire logic [23:0] array_addr;
    wire logic [7:0]  status_byte;

    always #5 mclk = ~mclk;

    sfp_status_protect #(.TW_NS(TW), .MFR_ID(MFR), .MEM_TYPE(TYP), .MEM_CAP(CAP))
        sfp_status_protect_i (.mclk, .resetn, .spi_sel_n, .spi_clk, .spi_din, .wp_n,
        .array_busy, .array_done, .spi_dout, .spi_dout_oe, .array_go, .array_op,
        .array_addr, .status_byte, .hw_protect);
    sfp_host_model sfp_host_model_i (.spi_dout, .spi_dout_oe, .spi_sel_n, .spi_clk,
        .spi_din, .wp_n);

    // Sequencer stand-in: busy long enough for frames to overlap it
    always @(posedge mclk)
    begin
        array_done <= 1'b0;
        if (array_go)
        begin
            go_n       <= go_n + 1;
            go_op      <= array_op;
            go_addr    <= array_addr;
            busy_cnt   <= 16'd800;
            array_busy <= 1'b1;
        end
        else if (busy_cnt == 16'd1)
        begin
            busy_cnt   <= 16'h0;
            array_busy <= 1'b0;
            array_done <= 1'b1;
        end
        else if (busy_cnt != 16'h0)
            busy_cnt <= busy_cnt - 16'd1;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic fr(input logic [31:0] tx, input int n);
        sfp_host_model_i.frame(tx, n);
        rx = sfp_host_model_i.rx;
    endtask : fr
    task automatic cmd(input logic [7:0] op);
        fr({op, 24'h0}, 8);
    endtask : cmd
    task automatic rd_st;
        fr({8'h05, 24'h0}, 16);
        st = rx[7:0];
    endtask : rd_st
    task automatic wr_st(input logic [7:0] d);
        cmd(8'h06);
        fr({8'h01, d, 16'h0}, 16);
    endtask : wr_st
    task automatic idle;
        repeat (40)
        begin
            rd_st();
            if (st[0] === 1'b0) break;
        end
    endtask : idle
    task automatic set_wp(input logic v);
        @(posedge mclk);
        sfp_host_model_i.wp_n <= v;
        repeat (6) @(posedge mclk);
    endtask : set_wp

    task automatic t_id;
        fr({8'h9f, 24'h0}, 32);
        chk("ident", {8'h0, MFR, TYP, CAP}, {8'h0, rx[23:0]});
        fr({8'h9f, 24'h0}, 13);
        chk("ident cut", {27'h0, MFR[7:3]}, {27'h0, rx[4:0]});
        rd_st();
        chk("status after cut", 32'h0, {24'h0, st});
    endtask : t_id
    task automatic t_status;
        cmd(8'h06);
        rd_st();
        chk("latch set", 32'h02, {24'h0, st});
        fr({8'h01, 8'hff, 16'h0}, 16);
        fr({8'h05, 24'h0}, 24);
        chk("busy repeat", 32'h0303, {16'h0, rx[15:0]});
        idle();
        chk("status written", 32'h9c, {24'h0, st});
    endtask : t_status
    task automatic t_refuse;
        fr({8'h01, 8'h00, 16'h0}, 16);
        rd_st();
        chk("no latch", 32'h9c, {24'h0, st});
        cmd(8'h06);
        fr({8'h01, 8'h00, 16'h0}, 15);
        rd_st();
        chk("off boundary", 32'h9e, {24'h0, st});
        fr({8'h01, 24'h0}, 24);
        rd_st();
        chk("long frame", 32'h9e, {24'h0, st});
    endtask : t_refuse
    task automatic t_hpm;
        set_wp(1'b0);
        chk("hpm on", 32'h1, {31'h0, hw_protect});
        fr({8'h01, 8'h00, 16'h0}, 16);
        rd_st();
        chk("hpm frozen", 32'h9e, {24'h0, st});
        set_wp(1'b1);
        chk("hpm off", 32'h0, {31'h0, hw_protect});
        wr_st(8'h00);
        idle();
        chk("cleared", 32'h0, {24'h0, st});
        set_wp(1'b0);
        wr_st(8'h84);
        idle();
        chk("pin low write", 32'h84, {24'h0, st});
        chk("hpm bit last", 32'h1, {31'h0, hw_protect});
        set_wp(1'b1);
    endtask : t_hpm
    task automatic t_array;
        int n;
        n = go_n;
        cmd(8'h06);
        cmd(8'hc7);
        chk("bulk refused", n, go_n);
        fr({8'hd8, 24'h07_0000}, 32);
        chk("locked sector", n, go_n);
        fr({8'hd8, 24'h06_0000}, 32);
        chk("free sector count", n + 1, go_n);
        chk("free sector op", {6'h0, 2'h2, 24'h06_0000}, {6'h0, go_op, go_addr});
        fr({8'h9f, 24'h0}, 32);
        chk("id while busy", 32'hzzzz_zzzz, rx);
        rd_st();
        chk("busy seen", 32'h87, {24'h0, st});
        idle();
        chk("erase done", 32'h84, {24'h0, st});
        wr_st(8'h00);
        idle();
        cmd(8'h06);
        cmd(8'hc7);
        chk("bulk go count", n + 2, go_n);
        chk("bulk go op", 32'h3, {30'h0, go_op});
        idle();
    endtask : t_array

    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    initial
    begin
        #300_000;
        err_count++;
        test_done();
    end

    initial
    begin
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
        t_id();
        t_status();
        t_refuse();
        t_hpm();
        t_array();
        test_done();
    end
endmodule : tb

`default_nettype wire

// ### hw/sfp_pkg.sv
`default_nettype none

package sfp_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int TW_DEFAULT_NS = 5000000;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] WRITE_ENABLE_CMD        = 8'h06;
    localparam logic [7:0] WRITE_DISABLE_CMD       = 8'h04;
    localparam logic [7:0] READ_IDENTIFICATION_CMD = 8'h9f;
    localparam logic [7:0] STATUS_READ_CMD         = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD        = 8'h01;
    localparam logic [7:0] PAGE_PROGRAM_CMD        = 8'h02;
    localparam logic [7:0] SECTOR_ERASE_CMD        = 8'hd8;
    localparam logic [7:0] BULK_ERASE_CMD          = 8'hc7;

    // ------------------------------------------------------------
    // Status register layout and reset values
    // ------------------------------------------------------------
    localparam int STAT_IN_PROGRESS_POS   = 0;
    localparam int STAT_WEL_POS           = 1;
    localparam int STAT_BP_LO_POS         = 2;
    localparam int STAT_BP_HI_POS         = 4;
    localparam int STAT_WRITE_DISABLE_POS = 7;
    localparam logic       STATUS_WRITE_DISABLE_BIT_RESET     = 1'b0;
    localparam logic [2:0] BP_RESET       = 3'h0;

    // ------------------------------------------------------------
    // Frame byte counts, including the opcode byte
    // ------------------------------------------------------------
    localparam logic [2:0] BYTES_SHORT_CMD  = 3'h1;
    localparam logic [2:0] BYTES_STATUS_WR  = 3'h2;
    localparam logic [2:0] BYTES_ERASE_SECT = 3'h4;
    localparam logic [2:0] BYTES_PROG_MIN   = 3'h5;
    localparam logic [2:0] BYTES_ADDR_LAST  = 3'h3;
    localparam int         SECTOR_LSB       = 16;

    typedef enum logic [1:0] {
        ST_CMD     = 2'b00,
        ST_COLLECT = 2'b01,
        ST_READOUT = 2'b10,
        ST_IGNORE  = 2'b11
    } sfp_link_state_t;

    typedef enum logic [1:0] {
        ARR_NONE    = 2'b00,
        ARR_PROGRAM = 2'b01,
        ARR_SECTOR  = 2'b10,
        ARR_BULK    = 2'b11
    } sfp_array_op_t;

endpackage : sfp_pkg

`default_nettype wire

// ### hw/sfp_status_protect.sv
// Notes on behaviour
// - Identification returns manufacturer byte, then memory type byte, then capacity byte.
// - Identification bits leave MSB first, changing on each falling serial clock edge.
// - Identification opcode during a program or erase cycle is ignored entirely.
// - Raising select ends any readout; device then waits for the next selection.
// - Status read is honoured at any time, even during self-timed cycles.
// - Status read keeps repeating the current status byte while select stays low.
// - In-progress flag is 1 during status-write, program or erase, else 0.
// - Write-enable flag mirrors the latch; cleared latch refuses all write commands.
// - Block-protect bits change only by status write, never in hardware protection.
// - Nonzero block-protect bits reject program and sector erase in protected area.
// - Bulk erase runs only when all block-protect bits are zero.
// - Disable bit high and protect pin low freeze bits and reject status writes.
// - Status write is accepted only after write-enable has set the latch.
// - Status write frame is opcode then exactly one data byte.
// - Status write ignores data bits b6, b5, b1, b0; b6 and b5 read as zero.
// - Status write is discarded unless select rises right after the data byte.
// - Valid status write starts timed cycle; at its end clear busy and latch.
// - With disable bit zero, status writes work whatever the protect pin level.
// - Hardware protection is entered whichever of bit and pin comes first.
// - Hardware protection is left only by driving the protect pin high.
// - All opcode, address and data bytes travel MSB first.
// - Write-enable command sets the write-enable latch.
// - Completing a status write clears the write-enable latch.
`default_nettype none

module sfp_status_protect #(
    parameter int          TW_NS      = sfp_pkg::TW_DEFAULT_NS, // Status write cycle time, ns
    parameter logic [31:0] PROT_TABLE = 32'h8888_4210,          // Top sectors locked per bp value
    parameter logic [7:0]  MFR_ID     = 8'ha5,                  // Arbitrary value
    parameter logic [7:0]  MEM_TYPE   = 8'h5a,                  // Arbitrary value
    parameter logic [7:0]  MEM_CAP    = 8'h3c                   // Arbitrary value
) (
    input  wire logic        mclk,           // System clock
    input  wire logic        resetn,         // Synchronous reset, active low
    input  wire logic        spi_sel_n,      // Chip select pin, active low
    input  wire logic        spi_clk,        // Serial clock pin
    input  wire logic        spi_din,        // Serial data in pin
    input  wire logic        wp_n,           // Write protect pin, active low
    input  wire logic        array_busy,     // Sequencer runs a program or erase
    input  wire logic        array_done,     // Sequencer finished an operation
    output logic             spi_dout,       // Serial data out
    output logic             spi_dout_oe,    // Drive enable for serial data out
    output logic             array_go,       // One-cycle start pulse to sequencer
    output logic [1:0]       array_op,       // Operation kind for array_go
    output logic [23:0]      array_addr,     // Address for array_go
    output logic [7:0]       status_byte,    // Current status register
    output logic             hw_protect      // Hardware protected mode active
);

    // ------------------------------------------------------------
    // Derived constants and checks
    // ------------------------------------------------------------
    localparam int TW_CYC = (TW_NS + sfp_pkg::CLK_PERIOD_NS - 1) / sfp_pkg::CLK_PERIOD_NS;
    localparam int TW_CYCLES = (TW_CYC < 1) ? 1 : TW_CYC;
    localparam int TW_W = $clog2(TW_CYCLES + 1);

    generate
        if (TW_NS < 1)
        begin : g_bad_tw
            $error("TW_NS must be positive");
        end
    endgenerate

    // Lookup of how many top sectors a block-protect value locks
    function automatic logic sector_locked(input logic [2:0] bp, input logic [2:0] sector);
        logic [3:0] n;
        n = PROT_TABLE[{bp, 2'b00} +: 4];
        return ({1'b0, sector} >= (4'h8 - n)) && (n != 4'h0);
    endfunction : sector_locked

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic       clk_prev_q;
    logic       sel_prev_q;

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            sync1_q    <= 4'hd;
            sync2_q    <= 4'hd;
            clk_prev_q <= 1'b0;
            sel_prev_q <= 1'b1;
        end
        else
        begin
            sync1_q    <= {spi_sel_n, spi_din, spi_clk, wp_n};
            sync2_q    <= sync1_q;
            clk_prev_q <= sync2_q[1];
            sel_prev_q <= sync2_q[3];
        end
    end

    logic sel_n_s;
    logic din_s;
    logic clk_s;
    logic wp_n_s;
    logic clk_rise;
    logic clk_fall;
    logic cs_rise;

    assign sel_n_s  = sync2_q[3];
    assign din_s    = sync2_q[2];
    assign clk_s    = sync2_q[1];
    assign wp_n_s   = sync2_q[0];
    assign clk_rise = clk_s & ~clk_prev_q;
    assign clk_fall = ~clk_s & clk_prev_q;
    assign cs_rise  = sel_n_s & ~sel_prev_q;

    // ------------------------------------------------------------
    // Status state
    // ------------------------------------------------------------
    logic             status_write_disable_bit_q;
    logic [2:0]       bp_q;
    logic             wel_q;
    logic             wsr_busy_q;
    logic [TW_W-1:0]  tw_cnt_q;
    logic [7:0]       wsr_pend_q;
    logic             in_progress;
    logic             hardware_protected_mode;
    logic [7:0]       status_now;

    assign in_progress = wsr_busy_q | array_busy | array_go;
    assign hardware_protected_mode         = status_write_disable_bit_q & ~wp_n_s;

    always_comb
    begin
        status_now = 8'h00;
        status_now[sfp_pkg::STAT_IN_PROGRESS_POS] = in_progress;
        status_now[sfp_pkg::STAT_WEL_POS] = wel_q;
        status_now[sfp_pkg::STAT_BP_HI_POS:sfp_pkg::STAT_BP_LO_POS] = bp_q;
        status_now[sfp_pkg::STAT_WRITE_DISABLE_POS] = status_write_disable_bit_q;
    end

    // ------------------------------------------------------------
    // Serial receive and command decode
    // ------------------------------------------------------------
    sfp_pkg::sfp_link_state_t state_q;
    logic [7:0]  rx_sh_q;
    logic [2:0]  bit_cnt_q;
    logic [2:0]  byte_cnt_q;
    logic [7:0]  opcode_q;
    logic [23:0] addr_q;
    logic [7:0]  wsr_data_q;
    logic        read_id_q;
    logic [7:0]  rx_next;

    // Bytes arrive MSB first
    assign rx_next = {rx_sh_q[6:0], din_s};

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            state_q    <= sfp_pkg::ST_CMD;
            rx_sh_q    <= 8'h00;
            bit_cnt_q  <= 3'h0;
            byte_cnt_q <= 3'h0;
            opcode_q   <= 8'h00;
            addr_q     <= 24'h000000;
            wsr_data_q <= 8'h00;
            read_id_q  <= 1'b0;
        end
        else if (sel_n_s)
        begin
            // Deselected: drop to standby, next frame starts afresh
            state_q    <= sfp_pkg::ST_CMD;
            bit_cnt_q  <= 3'h0;
            byte_cnt_q <= 3'h0;
        end
        else if (clk_rise)
        begin
            rx_sh_q   <= rx_next;
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7)
            begin
                if (byte_cnt_q != 3'h7)
                begin
                    byte_cnt_q <= byte_cnt_q + 3'h1;
                end
                case (state_q)
                    sfp_pkg::ST_CMD:
                    begin
                        opcode_q <= rx_next;
                        case (rx_next)
                            sfp_pkg::STATUS_READ_CMD:
                            begin
                                state_q   <= sfp_pkg::ST_READOUT;
                                read_id_q <= 1'b0;
                            end
                            sfp_pkg::READ_IDENTIFICATION_CMD:
                            begin
                                // Not decoded at all while a cycle runs
                                state_q   <= in_progress ? sfp_pkg::ST_IGNORE
                                                         : sfp_pkg::ST_READOUT;
                                read_id_q <= 1'b1;
                            end
                            sfp_pkg::WRITE_ENABLE_CMD,
                            sfp_pkg::WRITE_DISABLE_CMD,
                            sfp_pkg::STATUS_WRITE_CMD,
                            sfp_pkg::PAGE_PROGRAM_CMD,
                            sfp_pkg::SECTOR_ERASE_CMD,
                            sfp_pkg::BULK_ERASE_CMD:
                            begin
                                state_q <= sfp_pkg::ST_COLLECT;
                            end
                            default:
                            begin
                                state_q <= sfp_pkg::ST_IGNORE;
                            end
                        endcase
                    end
                    sfp_pkg::ST_COLLECT:
                    begin
                        if (byte_cnt_q == sfp_pkg::BYTES_SHORT_CMD)
                        begin
                            wsr_data_q <= rx_next;
                        end
                        if (byte_cnt_q <= sfp_pkg::BYTES_ADDR_LAST)
                        begin
                            addr_q <= {addr_q[15:0], rx_next};
                        end
                    end
                    default:
                    begin
                        state_q <= state_q;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Frame end evaluation, latch, protection and timed cycle
    // ------------------------------------------------------------
    logic frame_ok;
    logic wsr_ok;
    logic [2:0] sect;

    // Write-type frames count only when select rises on a byte boundary
    assign frame_ok = cs_rise && (state_q == sfp_pkg::ST_COLLECT)
                      && (bit_cnt_q == 3'h0) && !in_progress;
    assign wsr_ok   = frame_ok && (opcode_q == sfp_pkg::STATUS_WRITE_CMD)
                      && (byte_cnt_q == sfp_pkg::BYTES_STATUS_WR)
                      && wel_q && !hardware_protected_mode;
    assign sect     = addr_q[sfp_pkg::SECTOR_LSB +: 3];

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            wel_q      <= 1'b0;
            wsr_busy_q <= 1'b0;
            tw_cnt_q   <= '0;
            wsr_pend_q <= 8'h00;
            status_write_disable_bit_q     <= sfp_pkg::STATUS_WRITE_DISABLE_BIT_RESET;
            bp_q       <= sfp_pkg::BP_RESET;
        end
        else if (wsr_busy_q)
        begin
            if (tw_cnt_q == TW_W'(TW_CYCLES - 1))
            begin
                // STATUS_WRITE_DISABLE_BIT and BP take the data; latch b1 and busy b0 clear; b6, b5 untouched
                wsr_busy_q <= 1'b0;
                wel_q      <= 1'b0;
                status_write_disable_bit_q     <= wsr_pend_q[sfp_pkg::STAT_WRITE_DISABLE_POS];
                bp_q       <= wsr_pend_q[sfp_pkg::STAT_BP_HI_POS:
                                         sfp_pkg::STAT_BP_LO_POS];
            end
            tw_cnt_q <= tw_cnt_q + TW_W'(1);
        end
        else if (wsr_ok)
        begin
            wsr_busy_q <= 1'b1;
            tw_cnt_q   <= '0;
            wsr_pend_q <= wsr_data_q;
        end
        else if (array_done)
        begin
            // A write enable ending in the same cycle still wins over the clear
            wel_q <= frame_ok && byte_cnt_q == sfp_pkg::BYTES_SHORT_CMD
                     && opcode_q == sfp_pkg::WRITE_ENABLE_CMD;
        end
        else if (frame_ok && byte_cnt_q == sfp_pkg::BYTES_SHORT_CMD)
        begin
            if (opcode_q == sfp_pkg::WRITE_ENABLE_CMD)
            begin
                wel_q <= 1'b1;
            end
            else if (opcode_q == sfp_pkg::WRITE_DISABLE_CMD)
            begin
                wel_q <= 1'b0;
            end
        end
    end

    // Array start requests go out only when latch and protection allow
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            array_go   <= 1'b0;
            array_op   <= sfp_pkg::ARR_NONE;
            array_addr <= 24'h000000;
        end
        else
        begin
            array_go <= 1'b0;
            if (frame_ok && wel_q)
            begin
                array_addr <= addr_q;
                if (opcode_q == sfp_pkg::PAGE_PROGRAM_CMD
                    && byte_cnt_q >= sfp_pkg::BYTES_PROG_MIN
                    && !sector_locked(bp_q, sect))
                begin
                    array_go <= 1'b1;
                    array_op <= sfp_pkg::ARR_PROGRAM;
                end
                else if (opcode_q == sfp_pkg::SECTOR_ERASE_CMD
                         && byte_cnt_q == sfp_pkg::BYTES_ERASE_SECT
                         && !sector_locked(bp_q, sect))
                begin
                    array_go <= 1'b1;
                    array_op <= sfp_pkg::ARR_SECTOR;
                end
                else if (opcode_q == sfp_pkg::BULK_ERASE_CMD
                         && byte_cnt_q == sfp_pkg::BYTES_SHORT_CMD
                         && bp_q == 3'h0)
                begin
                    array_go <= 1'b1;
                    array_op <= sfp_pkg::ARR_BULK;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Serial transmit
    // ------------------------------------------------------------
    logic [7:0] tx_sh_q;
    logic [2:0] tx_bit_q;
    logic [1:0] tx_idx_q;
    logic [7:0] next_byte;
    logic [7:0] cur_byte;

    always_comb
    begin
        next_byte = status_now;
        if (read_id_q)
        begin
            case (tx_idx_q)
                2'h0:    next_byte = MFR_ID;
                2'h1:    next_byte = MEM_TYPE;
                2'h2:    next_byte = MEM_CAP;
                default: next_byte = 8'h00;
            endcase
        end
    end

    // A fresh byte is sampled at its first bit so status stays live
    assign cur_byte = (tx_bit_q == 3'h0) ? next_byte : tx_sh_q;

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            spi_dout    <= 1'b0;
            spi_dout_oe <= 1'b0;
            tx_sh_q     <= 8'h00;
            tx_bit_q    <= 3'h0;
            tx_idx_q    <= 2'h0;
        end
        else if (sel_n_s || state_q != sfp_pkg::ST_READOUT)
        begin
            spi_dout_oe <= 1'b0;
            tx_bit_q    <= 3'h0;
            tx_idx_q    <= 2'h0;
        end
        else if (clk_fall)
        begin
            spi_dout_oe <= 1'b1;
            spi_dout    <= cur_byte[7];
            tx_sh_q     <= {cur_byte[6:0], 1'b0};
            tx_bit_q    <= tx_bit_q + 3'h1;
            if (tx_bit_q == 3'h7 && tx_idx_q != 2'h3)
            begin
                tx_idx_q <= tx_idx_q + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Registered status outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            status_byte <= 8'h00;
            hw_protect  <= 1'b0;
        end
        else
        begin
            status_byte <= status_now;
            hw_protect  <= hardware_protected_mode;
        end
    end

endmodule : sfp_status_protect

`default_nettype wire
